// file: rtl/iops_defines.svh
// Constants for the I/O pin function select block
`ifndef IOPS_DEFINES_SVH
`define IOPS_DEFINES_SVH

`define IOPS_ADDR_W           9
`define IOPS_DATA_W           8
`define IOPS_PIN_W            32
`define IOPS_DIV_W            16

`define IOPS_OFS_INT_ROUTE    9'h18E
`define IOPS_OFS_FUNC_CFG     9'h18F
`define IOPS_OFS_PULLUP0      9'h1E0

`define IOPS_WMASK_INT_ROUTE  8'hDE
`define IOPS_WMASK_FUNC_CFG   8'hFB
`define IOPS_WMASK_PULLUP0    8'hFF
`define IOPS_RESET_VAL        8'h00
`define IOPS_READ_IDLE        8'h00

`define IOPS_BIT_IRQ1_SEL     1
`define IOPS_BIT_READ_SRC     3
`define IOPS_BIT_DOUBLE       4
`define IOPS_BIT_HALF         5
`define IOPS_BIT_SDA_LO       6
`define IOPS_BIT_SDA_HI       7

`define IOPS_PIN_P1_5         13
`define IOPS_PIN_P1_7         15
`define IOPS_PIN_P3_3         19
`define IOPS_PIN_P4_2         26

`define IOPS_PU_GRP0          32'h0000_0006
`define IOPS_PU_GRP1          32'h0000_00C0
`define IOPS_PU_GRP2          32'h0000_0F00
`define IOPS_PU_GRP3          32'h0000_F000
`define IOPS_PU_GRP6          32'h0008_0000
`define IOPS_PU_GRP7          32'h00B0_0000
`define IOPS_PU_NONE          32'h0000_0000

`define IOPS_SDA_DLY_SHORT    3
`define IOPS_SDA_DLY_MID      11
`define IOPS_SDA_DLY_LONG     19

`endif

// file: rtl/iops_pin_select.sv
// Pin function select: interrupt routing, port read source, I2C rate, SDA delay, pull-ups
`timescale 1ns/1ps
`default_nettype none
`include "iops_defines.svh"

module iops_pin_select (
    input  wire logic                    i_core_clk,
    input  wire logic                    i_srst,
    input  wire logic                    i_clk_en,
    input  wire logic [`IOPS_ADDR_W-1:0] i_addr,
    input  wire logic [`IOPS_DATA_W-1:0] i_wdata,
    input  wire logic                    i_wr_stb,
    input  wire logic                    i_rd_stb,
    output logic      [`IOPS_DATA_W-1:0] o_rdata,
    input  wire logic [`IOPS_PIN_W-1:0]  i_pin_level,
    input  wire logic [`IOPS_PIN_W-1:0]  i_port_latch,
    input  wire logic [`IOPS_PIN_W-1:0]  i_port_dir,
    output logic      [`IOPS_PIN_W-1:0]  o_port_read,
    output logic                         o_ext_irq_one,
    input  wire logic                    i_serial_bus_switch,
    input  wire logic [`IOPS_DIV_W-1:0]  i_i2c_base_div,
    output logic      [`IOPS_DIV_W:0]    o_i2c_div,
    output logic                         o_rate_fault,
    input  wire logic                    i_sda_out,
    output logic                         o_sda_delayed,
    output logic      [`IOPS_PIN_W-1:0]  o_pullup_en
);

    iops_pkg::iops_state_t    state;
    iops_pkg::iops_state_t    next_state;
    logic [`IOPS_PIN_W-1:0]   pin_sync;
    logic [`IOPS_PIN_W-1:0]   group_mask;
    iops_pkg::iops_sda_code_t sda_code;
    logic                     read_src_pin;
    logic                     rate_double;
    logic                     rate_half;
    logic                     irq_sel;

    // Pin levels come from outside the clock domain
    iops_sync2 #(
        .WIDTH (`IOPS_PIN_W)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_clk_en   (i_clk_en),
        .i_async    (i_pin_level),
        .o_sync     (pin_sync)
    );

    assign irq_sel      = state.int_route[`IOPS_BIT_IRQ1_SEL];
    assign read_src_pin = state.func_cfg[`IOPS_BIT_READ_SRC];
    assign rate_double  = state.func_cfg[`IOPS_BIT_DOUBLE];
    assign rate_half    = state.func_cfg[`IOPS_BIT_HALF];
    assign sda_code     = iops_pkg::iops_sda_code_t'(
                              state.func_cfg[`IOPS_BIT_SDA_HI:`IOPS_BIT_SDA_LO]);

    // Pin-group masks of the enabled pull-up bits
    always_comb
    begin
        group_mask = `IOPS_PU_NONE;
        if (state.pullup0[0])
        begin
            group_mask = group_mask | `IOPS_PU_GRP0;
        end
        if (state.pullup0[1])
        begin
            group_mask = group_mask | `IOPS_PU_GRP1;
        end
        if (state.pullup0[2])
        begin
            group_mask = group_mask | `IOPS_PU_GRP2;
        end
        if (state.pullup0[3])
        begin
            group_mask = group_mask | `IOPS_PU_GRP3;
        end
        if (state.pullup0[6])
        begin
            group_mask = group_mask | `IOPS_PU_GRP6;
        end
        if (state.pullup0[7])
        begin
            group_mask = group_mask | `IOPS_PU_GRP7;
        end
    end

    always_comb
    begin
        next_state = state;
        if (i_clk_en)
        begin
            // Register writes; unassigned route and config bits are never stored, pull-up bits 4 and 5 are stored though they map to no pins
            if (i_wr_stb)
            begin
                case (i_addr)
                    `IOPS_OFS_INT_ROUTE:
                    begin
                        next_state.int_route = i_wdata & `IOPS_WMASK_INT_ROUTE;
                    end
                    `IOPS_OFS_FUNC_CFG:
                    begin
                        next_state.func_cfg = i_wdata & `IOPS_WMASK_FUNC_CFG;
                    end
                    `IOPS_OFS_PULLUP0:
                    begin
                        next_state.pullup0 = i_wdata & `IOPS_WMASK_PULLUP0;
                    end
                    default:
                    begin
                        next_state.pullup0 = state.pullup0;
                    end
                endcase
            end

            // Read data stand for one enabled cycle only
            next_state.rdata = `IOPS_READ_IDLE;
            if (i_rd_stb)
            begin
                case (i_addr)
                    `IOPS_OFS_INT_ROUTE: next_state.rdata = state.int_route;
                    `IOPS_OFS_FUNC_CFG:  next_state.rdata = state.func_cfg;
                    `IOPS_OFS_PULLUP0:   next_state.rdata = state.pullup0;
                    default:             next_state.rdata = `IOPS_READ_IDLE;
                endcase
            end

            // Interrupt input routing
            if (irq_sel)
            begin
                next_state.ext_irq_one = pin_sync[`IOPS_PIN_P1_5];
            end
            else
            begin
                next_state.ext_irq_one = pin_sync[`IOPS_PIN_P1_7];
            end

            // Port read source per bit
            for (int i = 0; i < `IOPS_PIN_W; i++)
            begin
                if (read_src_pin && (i != `IOPS_PIN_P4_2))
                begin
                    next_state.port_read[i] = pin_sync[i];
                end
                else if (i_port_dir[i])
                begin
                    next_state.port_read[i] = i_port_latch[i];
                end
                else
                begin
                    next_state.port_read[i] = pin_sync[i];
                end
            end

            // Pull-ups only on input-mode pins
            next_state.pullup_en = group_mask & ~i_port_dir;

            // Rate scaling only applies with the I2C function selected
            next_state.i2c_div    = {1'b0, i_i2c_base_div};
            next_state.rate_fault = 1'b0;
            if (i_serial_bus_switch)
            begin
                if (rate_double && rate_half)
                begin
                    next_state.rate_fault = 1'b1;
                end
                else if (rate_double)
                begin
                    next_state.i2c_div = {2'b00, i_i2c_base_div[`IOPS_DIV_W-1:1]};
                end
                else if (rate_half)
                begin
                    next_state.i2c_div = {i_i2c_base_div, 1'b0};
                end
            end
            else
            begin
                next_state.rate_fault = rate_double | rate_half;
            end
        end

        if (i_srst)
        begin
            next_state = '0;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        state <= next_state;
    end

    iops_sda_delay #(
        .DEPTH (`IOPS_SDA_DLY_LONG)
    ) u_sda_delay (
        .i_core_clk    (i_core_clk),
        .i_srst        (i_srst),
        .i_clk_en      (i_clk_en),
        .i_delay_code  (sda_code),
        .i_sda         (i_sda_out),
        .o_sda_delayed (o_sda_delayed)
    );

    assign o_rdata       = state.rdata;
    assign o_port_read   = state.port_read;
    assign o_ext_irq_one = state.ext_irq_one;
    assign o_i2c_div     = state.i2c_div;
    assign o_rate_fault  = state.rate_fault;
    assign o_pullup_en   = state.pullup_en;

    sequence s_read_int_route;
        i_clk_en && i_rd_stb && (i_addr == `IOPS_OFS_INT_ROUTE);
    endsequence

    sequence s_write_route_sel;
        i_clk_en && i_wr_stb && (i_addr == `IOPS_OFS_INT_ROUTE)
            && i_wdata[`IOPS_BIT_IRQ1_SEL];
    endsequence

    sequence s_read_func_cfg;
        i_clk_en && i_rd_stb && (i_addr == `IOPS_OFS_FUNC_CFG);
    endsequence

    sequence s_read_unmapped;
        i_clk_en && i_rd_stb && (i_addr != `IOPS_OFS_INT_ROUTE)
            && (i_addr != `IOPS_OFS_FUNC_CFG) && (i_addr != `IOPS_OFS_PULLUP0);
    endsequence

    property p_route_takes_p1_5;
        @(posedge i_core_clk) disable iff (i_srst)
        s_write_route_sel ##1 i_clk_en
            |=> o_ext_irq_one == $past(pin_sync[`IOPS_PIN_P1_5]);
    endproperty

    AST_IRQ_ROUTE_P1_5: assert property (p_route_takes_p1_5)
        else $error("Interrupt input not taken from P1_5");

    AST_IRQ_ROUTE_P1_7: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        (i_clk_en && !irq_sel) |=> o_ext_irq_one == $past(pin_sync[`IOPS_PIN_P1_7]))
        else $error("Interrupt input not taken from P1_7");

    AST_READ_LATCH_OUT: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        (i_clk_en && !read_src_pin)
            |=> ((o_port_read ^ $past(i_port_latch)) & $past(i_port_dir)) == '0)
        else $error("Output-mode bit did not read the latch");

    AST_READ_PIN_ALL: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        (i_clk_en && read_src_pin)
            |=> ((o_port_read ^ $past(pin_sync)) & ~(`IOPS_PIN_W'(1) << `IOPS_PIN_P4_2)) == '0)
        else $error("Pin level not read with source bit set");

    AST_P4_2_NORMAL: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        (i_clk_en && i_port_dir[`IOPS_PIN_P4_2])
            |=> o_port_read[`IOPS_PIN_P4_2] == $past(i_port_latch[`IOPS_PIN_P4_2]))
        else $error("P4_2 output bit did not read its latch");

    AST_RATE_DOUBLE: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        (i_clk_en && i_serial_bus_switch && rate_double && !rate_half)
            |=> o_i2c_div == ($past(i_i2c_base_div) >> 1))
        else $error("Double rate did not halve the divisor");

    AST_RATE_HALF: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        (i_clk_en && i_serial_bus_switch && rate_half && !rate_double)
            |=> o_i2c_div == {$past(i_i2c_base_div), 1'b0})
        else $error("Half rate did not double the divisor");

    AST_SSU_NO_SCALE: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        (i_clk_en && !i_serial_bus_switch)
            |=> o_i2c_div == {1'b0, $past(i_i2c_base_div)})
        else $error("Rate scaled while SYNCHRONOUS_SERIAL_UNIT selected");

    AST_PULLUP_GROUP: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        (i_clk_en && state.pullup0[6] && !i_port_dir[`IOPS_PIN_P3_3])
            |=> o_pullup_en[`IOPS_PIN_P3_3])
        else $error("P3_3 pull-up not enabled by its group bit");

    AST_PULLUP_INPUT_ONLY: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        i_clk_en |=> (o_pullup_en & $past(i_port_dir)) == '0)
        else $error("Pull-up active on an output pin");

    AST_UNASSIGNED_ZERO: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        s_read_int_route |=> (o_rdata[0] == 1'b0) && (o_rdata[5] == 1'b0))
        else $error("Unassigned route bits read nonzero");

    AST_RESET_ZERO: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        $fell(i_srst) |-> (state.int_route == `IOPS_RESET_VAL)
            && (state.func_cfg == `IOPS_RESET_VAL)
            && (state.pullup0 == `IOPS_RESET_VAL))
        else $error("Registers not zero after reset");

    AST_CFG_UNASSIGNED_ZERO: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        s_read_func_cfg |=> (o_rdata & ~`IOPS_WMASK_FUNC_CFG) == '0)
        else $error("Unassigned config bit reads nonzero");

    AST_UNMAPPED_READ_ZERO: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        s_read_unmapped |=> o_rdata == `IOPS_READ_IDLE)
        else $error("Unmapped address reads nonzero");

    AST_READ_PIN_INPUT: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        (i_clk_en && !read_src_pin)
            |=> ((o_port_read ^ $past(pin_sync)) & ~$past(i_port_dir)) == '0)
        else $error("Input-mode bit did not read the pin");

    AST_RATE_PLAIN: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        (i_clk_en && i_serial_bus_switch && !rate_double && !rate_half)
            |=> o_i2c_div == {1'b0, $past(i_i2c_base_div)})
        else $error("Divisor scaled with both rate bits clear");

    AST_RATE_FAULT_BOTH: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        (i_clk_en && i_serial_bus_switch && rate_double && rate_half)
            |=> o_rate_fault)
        else $error("Both rate bits set without a fault");

    AST_PULLUP_P0_LOW: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        (i_clk_en && (state.pullup0 == 8'h01) && (i_port_dir == '0))
            |=> o_pullup_en == `IOPS_PU_GRP0)
        else $error("First pull-up group mask wrong");

endmodule : iops_pin_select

`default_nettype wire

// file: rtl/iops_pkg.sv
// Types shared by the I/O pin function select block
`include "iops_defines.svh"

package iops_pkg;

    typedef enum logic [1:0]
    {
        IOPS_SDA_SHORT   = 2'b00,
        IOPS_SDA_MID     = 2'b01,
        IOPS_SDA_LONG    = 2'b10,
        IOPS_SDA_ILLEGAL = 2'b11
    } iops_sda_code_t;

    typedef struct packed
    {
        logic [`IOPS_DATA_W-1:0] int_route;
        logic [`IOPS_DATA_W-1:0] func_cfg;
        logic [`IOPS_DATA_W-1:0] pullup0;
        logic [`IOPS_DATA_W-1:0] rdata;
        logic                    ext_irq_one;
        logic [`IOPS_PIN_W-1:0]  port_read;
        logic [`IOPS_PIN_W-1:0]  pullup_en;
        logic [`IOPS_DIV_W:0]    i2c_div;
        logic                    rate_fault;
    } iops_state_t;

endpackage : iops_pkg

// file: rtl/iops_sda_delay.sv
// Digital SDA delay line with selectable length
`timescale 1ns/1ps
`default_nettype none
`include "iops_defines.svh"

module iops_sda_delay #(
    parameter int DEPTH = `IOPS_SDA_DLY_LONG
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_srst,
    input  wire logic                  i_clk_en,
    input  wire iops_pkg::iops_sda_code_t i_delay_code,
    input  wire logic                  i_sda,
    output logic                       o_sda_delayed
);

    localparam int IDX_W = $clog2(DEPTH);

    typedef struct packed
    {
        logic [DEPTH-1:0] taps;
    } iops_dly_state_t;

    iops_dly_state_t  state;
    iops_dly_state_t  next_state;
    logic [IDX_W-1:0] tap_sel;

    always_comb
    begin
        next_state = state;
        if (i_clk_en)
        begin
            next_state.taps = {state.taps[DEPTH-2:0], i_sda};
        end
        if (i_srst)
        begin
            next_state = '0;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        state <= next_state;
    end

    // Code 11 is not allowed; it falls back to the longest delay
    always_comb
    begin
        case (i_delay_code)
            iops_pkg::IOPS_SDA_SHORT: tap_sel = IDX_W'(`IOPS_SDA_DLY_SHORT - 1);
            iops_pkg::IOPS_SDA_MID:   tap_sel = IDX_W'(`IOPS_SDA_DLY_MID - 1);
            iops_pkg::IOPS_SDA_LONG:  tap_sel = IDX_W'(`IOPS_SDA_DLY_LONG - 1);
            default:                  tap_sel = IDX_W'(DEPTH - 1);
        endcase
    end

    assign o_sda_delayed = state.taps[tap_sel];

    sequence s_three_enabled;
        i_clk_en [*3];
    endsequence

    property p_short_delay;
        @(posedge i_core_clk) disable iff (i_srst)
        s_three_enabled ##1 (i_delay_code == iops_pkg::IOPS_SDA_SHORT)
            |-> o_sda_delayed == $past(i_sda, 3);
    endproperty

    AST_SDA_SHORT_DELAY: assert property (p_short_delay)
        else $error("SDA short delay is not three cycles");

endmodule : iops_sda_delay

`default_nettype wire

// file: rtl/iops_sync2.sv
// Two-stage synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none

module iops_sync2 #(
    parameter int WIDTH = 32
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_srst,
    input  wire logic             i_clk_en,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    typedef struct packed
    {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } iops_sync_state_t;

    iops_sync_state_t state;
    iops_sync_state_t next_state;

    always_comb
    begin
        next_state = state;
        if (i_clk_en)
        begin
            next_state.meta   = i_async;
            next_state.stable = state.meta;
        end
        if (i_srst)
        begin
            next_state = '0;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        state <= next_state;
    end

    assign o_sync = state.stable;

endmodule : iops_sync2

`default_nettype wire

// file: verification/iops_testbench.sv
// Self-checking testbench for the I/O pin function select block
`timescale 1ns/1ps
`default_nettype none
`include "iops_defines.svh"

module testbench;
    localparam int LIMIT = 6000;

    logic        core_clk;
    logic        srst;
    logic        clk_en;
    logic [8:0]  addr;
    logic [7:0]  wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [7:0]  rdata;
    logic [31:0] pin_level;
    logic [31:0] port_latch;
    logic [31:0] port_dir;
    logic [31:0] port_read;
    logic        ext_irq_one;
    logic        bus_switch;
    logic [15:0] base_div;
    logic [16:0] i2c_div;
    logic        rate_fault;
    logic        sda_out;
    logic        sda_delayed;
    logic [31:0] pullup_en;
    int          num_errors;
    int          comparisons;
    int          cycles = 0;

    iops_pin_select dut (
        .i_core_clk          (core_clk),
        .i_srst              (srst),
        .i_clk_en            (clk_en),
        .i_addr              (addr),
        .i_wdata             (wdata),
        .i_wr_stb            (wr_stb),
        .i_rd_stb            (rd_stb),
        .o_rdata             (rdata),
        .i_pin_level         (pin_level),
        .i_port_latch        (port_latch),
        .i_port_dir          (port_dir),
        .o_port_read         (port_read),
        .o_ext_irq_one       (ext_irq_one),
        .i_serial_bus_switch (bus_switch),
        .i_i2c_base_div      (base_div),
        .o_i2c_div           (i2c_div),
        .o_rate_fault        (rate_fault),
        .i_sda_out           (sda_out),
        .o_sda_delayed       (sda_delayed),
        .o_pullup_en         (pullup_en)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic complete_run();
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    // Hang guard
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            num_errors++;
            $display("[ERR] %0t run did not finish", $time);
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc

    task automatic reg_wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd

    task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        reg_rd(a, d);
        chk({24'h0, d}, {24'h0, exp}, what);
    endtask : rd_chk

    task automatic test_reset_and_masks();
        rd_chk(`IOPS_OFS_INT_ROUTE, 8'h00, "route reset");
        wait_cyc(1);
        chk({24'h0, rdata}, 32'h0, "read data not cleared");
        rd_chk(`IOPS_OFS_FUNC_CFG, 8'h00, "config reset");
        rd_chk(`IOPS_OFS_PULLUP0, 8'h00, "pull-up reset");
        clk_en <= 1'b0;
        reg_wr(`IOPS_OFS_PULLUP0, 8'hFF);
        clk_en <= 1'b1;
        rd_chk(`IOPS_OFS_PULLUP0, 8'h00, "write while frozen");
        reg_wr(9'h18D, 8'hFF);
        rd_chk(9'h18D, 8'h00, "unmapped read");
        reg_wr(`IOPS_OFS_INT_ROUTE, 8'hFF);
        rd_chk(`IOPS_OFS_INT_ROUTE, 8'hDE, "route unassigned bits");
        reg_wr(`IOPS_OFS_FUNC_CFG, 8'hFF);
        rd_chk(`IOPS_OFS_FUNC_CFG, 8'hFB, "config unassigned bit");
        reg_wr(`IOPS_OFS_PULLUP0, 8'hFF);
        rd_chk(`IOPS_OFS_PULLUP0, 8'hFF, "pull-up readback");
        reg_wr(`IOPS_OFS_INT_ROUTE, 8'h00);
        reg_wr(`IOPS_OFS_FUNC_CFG, 8'h00);
        reg_wr(`IOPS_OFS_PULLUP0, 8'h00);
    endtask : test_reset_and_masks

    task automatic test_irq_route();
        pin_level <= 32'h1 << `IOPS_PIN_P1_7;
        wait_cyc(5);
        chk({31'h0, ext_irq_one}, 32'h1, "irq from first pin");
        reg_wr(`IOPS_OFS_INT_ROUTE, 8'h02);
        wait_cyc(3);
        chk({31'h0, ext_irq_one}, 32'h0, "irq ignores first pin");
        pin_level <= 32'h1 << `IOPS_PIN_P1_5;
        wait_cyc(5);
        chk({31'h0, ext_irq_one}, 32'h1, "irq from second pin");
        reg_wr(`IOPS_OFS_INT_ROUTE, 8'h00);
        wait_cyc(3);
        chk({31'h0, ext_irq_one}, 32'h0, "irq back on first pin");
    endtask : test_irq_route

    task automatic test_port_read();
        logic [31:0] exp0;
        logic [31:0] exp1;
        logic [31:0] m26;
        m26        = 32'h1 << `IOPS_PIN_P4_2;
        port_dir   <= 32'h5555_5555;
        port_latch <= 32'h0F0F_0F0F;
        pin_level  <= 32'h383C_3C3C;
        exp0       = (32'h5555_5555 & 32'h0F0F_0F0F) | (32'hAAAA_AAAA & 32'h383C_3C3C);
        exp1       = (32'h383C_3C3C & ~m26) | (exp0 & m26);
        wait_cyc(5);
        chk(port_read, exp0, "port read by direction");
        reg_wr(`IOPS_OFS_FUNC_CFG, 8'h08);
        wait_cyc(3);
        chk(port_read, exp1, "port read pin level");
        reg_wr(`IOPS_OFS_FUNC_CFG, 8'h00);
        wait_cyc(3);
        chk(port_read, exp0, "port read back to latch");
        port_dir <= 32'h0;
    endtask : test_port_read

    task automatic test_i2c_rate();
        logic [7:0]  cfg [6];
        logic [31:0] div [6];
        logic        sw  [6];
        logic        flt [6];
        cfg = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h10, 8'h00};
        div = '{32'd100, 32'd50, 32'd200, 32'd100, 32'd100, 32'd100};
        sw  = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        flt = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        base_div <= 16'h0064;
        for (int i = 0; i < 6; i++)
        begin
            bus_switch <= sw[i];
            reg_wr(`IOPS_OFS_FUNC_CFG, cfg[i]);
            wait_cyc(3);
            chk({15'h0, i2c_div}, div[i], "i2c divisor");
            chk({31'h0, rate_fault}, {31'h0, flt[i]}, "rate fault");
        end
    endtask : test_i2c_rate

    task automatic test_sda_delay();
        int n;
        int exp [3];
        exp = '{3, 11, 19};
        for (int c = 0; c < 3; c++)
        begin
            sda_out <= 1'b0;
            reg_wr(`IOPS_OFS_FUNC_CFG, 8'(c << 6));
            wait_cyc(25);
            @(posedge core_clk);
            sda_out <= 1'b1;
            n = 0;
            while (n < 40)
            begin
                @(posedge core_clk);
                n++;
                #1;
                if (sda_delayed === 1'b1)
                    break;
            end
            chk(32'(n), 32'(exp[c]), "sda delay cycles");
        end
        sda_out <= 1'b0;
        reg_wr(`IOPS_OFS_FUNC_CFG, 8'h00);
    endtask : test_sda_delay

    task automatic test_pullup();
        logic [31:0] grp [8];
        logic [31:0] all;
        grp = '{`IOPS_PU_GRP0, `IOPS_PU_GRP1, `IOPS_PU_GRP2, `IOPS_PU_GRP3,
                `IOPS_PU_NONE, `IOPS_PU_NONE, `IOPS_PU_GRP6, `IOPS_PU_GRP7};
        all = 32'h0;
        port_dir <= 32'h0;
        for (int b = 0; b < 8; b++)
        begin
            reg_wr(`IOPS_OFS_PULLUP0, 8'(1 << b));
            wait_cyc(3);
            chk(pullup_en, grp[b], "pull-up group");
            all = all | grp[b];
        end
        reg_wr(`IOPS_OFS_PULLUP0, 8'hFF);
        port_dir <= 32'h0020_5042;
        wait_cyc(3);
        chk(pullup_en, all & ~32'h0020_5042, "pull-up input pins only");
        port_dir <= 32'hFFFF_FFFF;
        wait_cyc(3);
        chk(pullup_en, 32'h0, "pull-up all outputs");
        reg_wr(`IOPS_OFS_PULLUP0, 8'h00);
        port_dir <= 32'h0;
    endtask : test_pullup

    task automatic test_mid_reset();
        reg_wr(`IOPS_OFS_INT_ROUTE, 8'h02);
        reg_wr(`IOPS_OFS_PULLUP0, 8'hFF);
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        rd_chk(`IOPS_OFS_INT_ROUTE, 8'h00, "route after reset");
        rd_chk(`IOPS_OFS_PULLUP0, 8'h00, "pull-up after reset");
        chk(pullup_en, 32'h0, "pull-up enables after reset");
    endtask : test_mid_reset

    initial
    begin
        srst        = 1'b1;
        clk_en      = 1'b1;
        addr        = 9'h000;
        wdata       = 8'h00;
        wr_stb      = 1'b0;
        rd_stb      = 1'b0;
        pin_level   = 32'h0;
        port_latch  = 32'h0;
        port_dir    = 32'h0;
        bus_switch  = 1'b0;
        base_div    = 16'h0000;
        sda_out     = 1'b0;
        num_errors  = 0;
        comparisons = 0;
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        test_reset_and_masks();
        test_irq_route();
        test_port_read();
        test_i2c_rate();
        test_sda_delay();
        test_pullup();
        test_mid_reset();
        complete_run();
    end
endmodule : testbench

`default_nettype wire
